// >>> cct_pkg.sv
package cct_pkg;
    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CCT_CTRL_OFS     = 8'h00;
    localparam logic [7:0] CCT_TMR_A_OFS    = 8'h04;
    localparam logic [7:0] CCT_RLD_A_OFS    = 8'h08;
    localparam logic [7:0] CCT_TMR_B_OFS    = 8'h0C;
    localparam logic [7:0] CCT_RLD_B_OFS    = 8'h10;
    localparam logic [7:0] CCT_STATUS_OFS   = 8'h14;
    localparam logic [7:0] CCT_MASK_OFS     = 8'h18;
    localparam logic [7:0] CCT_DBL_OFS      = 8'h1C;
    localparam logic [7:0] CCT_PIN_OFS      = 8'h20;
    localparam logic [1:0] CCT_CH_CTRL_PAGE = 2'h1;   // 0x40 + 4*ch
    localparam logic [1:0] CCT_CH_VAL_PAGE  = 2'h2;   // 0x80 + 4*ch

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CCT_CTRL_STAGGER = 0;
    localparam int CCT_CTRL_RUN_A   = 1;
    localparam int CCT_CTRL_RUN_B   = 2;
    localparam int CCT_CTRL_SEL_A   = 3;   // 3 bits
    localparam int CCT_CTRL_SEL_B   = 6;   // 3 bits
    localparam int CCT_CTRL_W       = 9;

    // Clock select codes: 0..5 prescale by 2**code
    localparam logic [2:0] CCT_SEL_MAX_PSC = 3'h5;
    localparam logic [2:0] CCT_SEL_GP_OVF  = 3'h6;
    localparam logic [2:0] CCT_SEL_EXT_CNT = 3'h7;

    // Channel control fields
    localparam int CCT_CH_MODE   = 0;   // 3 bits
    localparam int CCT_CH_TSEL   = 3;
    localparam int CCT_CH_SINGLE = 4;
    localparam int CCT_CH_CTRL_W = 5;

    // Status bits 16 and 17 are time base overflows
    localparam int CCT_ST_OVF_A = 16;
    localparam int CCT_ST_OVF_B = 17;
    localparam int CCT_ST_W     = 18;

    localparam logic [15:0] CCT_RESET_16 = 16'h0000;
    localparam logic [15:0] CCT_TMR_TOP  = 16'hFFFF;
    localparam int          CCT_STAGGER_SLOTS = 8;

    typedef enum logic [2:0] {
        CCT_OFF,
        CCT_CAP_RISE,
        CCT_CAP_FALL,
        CCT_CAP_BOTH,
        CCT_CMP0,
        CCT_CMP1,
        CCT_CMP2,
        CCT_CMP3
    } cct_mode_t;
endpackage

// >>> cct_capcom.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cct_capcom
    import cct_pkg::*;
#(
    parameter int NCH = 16
) (
    input  wire logic             hclk,        // Bus and core clock
    input  wire logic             hresetn,     // Async reset
    input  wire logic             hsel,        // Slave select
    input  wire logic [31:0]      haddr,       // Address
    input  wire logic [1:0]       htrans,      // Transfer type
    input  wire logic             hwrite,      // Write
    input  wire logic [2:0]       hsize,       // Size, word only
    input  wire logic [31:0]      hwdata,      // Write data
    input  wire logic             hready,      // Bus ready
    output logic                  hreadyout,   // Ready out
    output logic                  hresp,       // Response, always OKAY
    output logic [31:0]           hrdata,      // Read data
    input  wire logic [NCH-1:0]   pin_in,      // Channel pins, input side
    output logic [NCH-1:0]        pin_out,     // Channel pins, output level
    output logic [NCH-1:0]        pin_oe_n,    // Low while driving
    input  wire logic             gp_ovf_in,   // External timer overflow pulse
    input  wire logic             ext_cnt_in,  // External count pin
    output logic                  irq          // Interrupt level
);
    // ****************************************
    // Bus slave
    // ****************************************
    logic        hreadyout_reg, wr_pend_reg;
    logic [31:0] hrdata_reg, rd_next;
    logic [7:0]  wr_addr_reg;
    logic        addr_ok;

    logic [CCT_CTRL_W-1:0]    ctrl_reg;
    logic [15:0]              tmr_reg [2];
    logic [15:0]              rld_reg [2];
    logic [CCT_ST_W-1:0]      status_reg, mask_reg, st_set;
    logic [7:0]               dbl_reg;
    logic [CCT_CH_CTRL_W-1:0] cctl_reg [NCH];
    logic [15:0]              cval_reg [NCH];
    logic [NCH-1:0]           pin_reg, oe_n_reg, fire;
    logic                     irq_reg;

    assign addr_ok   = hsel && htrans[1] && hready;
    assign hreadyout = hreadyout_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    always_comb begin
        rd_next = '0;
        if (haddr[7:0] == CCT_CTRL_OFS) begin
            rd_next[CCT_CTRL_W-1:0] = ctrl_reg;
        end else if (haddr[7:0] == CCT_TMR_A_OFS) begin
            rd_next[15:0] = tmr_reg[0];
        end else if (haddr[7:0] == CCT_RLD_A_OFS) begin
            rd_next[15:0] = rld_reg[0];
        end else if (haddr[7:0] == CCT_TMR_B_OFS) begin
            rd_next[15:0] = tmr_reg[1];
        end else if (haddr[7:0] == CCT_RLD_B_OFS) begin
            rd_next[15:0] = rld_reg[1];
        end else if (haddr[7:0] == CCT_STATUS_OFS) begin
            rd_next[CCT_ST_W-1:0] = status_reg;
        end else if (haddr[7:0] == CCT_MASK_OFS) begin
            rd_next[CCT_ST_W-1:0] = mask_reg;
        end else if (haddr[7:0] == CCT_DBL_OFS) begin
            rd_next[7:0] = dbl_reg;
        end else if (haddr[7:0] == CCT_PIN_OFS) begin
            rd_next[NCH-1:0] = pin_reg;
        end else if (haddr[7:6] == CCT_CH_CTRL_PAGE) begin
            rd_next[CCT_CH_CTRL_W-1:0] = cctl_reg[haddr[5:2]];
        end else if (haddr[7:6] == CCT_CH_VAL_PAGE) begin
            rd_next[15:0] = cval_reg[haddr[5:2]];
        end
    end

    // Zero wait states; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b0;
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 8'h00;
            hrdata_reg    <= 32'h0000_0000;
        end else begin
            hreadyout_reg <= 1'b1;
            wr_pend_reg   <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata_reg <= rd_next;
            end
        end
    end

    function automatic logic wr_hit(input logic [7:0] ofs);
        return wr_pend_reg && (wr_addr_reg == ofs);
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= '0;
            mask_reg <= '0;
            dbl_reg  <= 8'h00;
        end else begin
            if (wr_hit(CCT_CTRL_OFS)) ctrl_reg <= hwdata[CCT_CTRL_W-1:0];
            if (wr_hit(CCT_MASK_OFS)) mask_reg <= hwdata[CCT_ST_W-1:0];
            if (wr_hit(CCT_DBL_OFS))  dbl_reg  <= hwdata[7:0];
        end
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [NCH-1:0] pin_s1, pin_s2, pin_s3;
    logic           ext_s1, ext_s2, ext_s3;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            ext_s1 <= ext_cnt_in;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // ****************************************
    // Time bases
    // ****************************************
    logic [4:0] psc_reg;
    logic [2:0] slot_reg;
    logic [1:0] tick, run, wr_tmr, step_reg, ovf_reg;
    logic [2:0] sel [2];
    logic       ext_edge, stagger;

    assign ext_edge = ext_s2 && !ext_s3;
    assign stagger  = ctrl_reg[CCT_CTRL_STAGGER];
    assign sel[0]   = ctrl_reg[CCT_CTRL_SEL_A +: 3];
    assign sel[1]   = ctrl_reg[CCT_CTRL_SEL_B +: 3];
    assign run      = {ctrl_reg[CCT_CTRL_RUN_B], ctrl_reg[CCT_CTRL_RUN_A]};
    assign wr_tmr   = {wr_hit(CCT_TMR_B_OFS), wr_hit(CCT_TMR_A_OFS)};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psc_reg  <= 5'h00;
            slot_reg <= 3'h0;
        end else begin
            psc_reg  <= psc_reg + 5'h01;
            slot_reg <= slot_reg + 3'h1;
        end
    end

    for (genvar t = 0; t < 2; t++) begin : g_tb
        logic [4:0] pmask;
        assign pmask = 5'((6'h01 << sel[t]) - 6'h01);
        always_comb begin
            if (sel[t] <= CCT_SEL_MAX_PSC) begin
                tick[t] = (psc_reg & pmask) == pmask;
            end else if (sel[t] == CCT_SEL_GP_OVF) begin
                tick[t] = gp_ovf_in;
            end else begin
                tick[t] = ext_edge;
            end
        end

        // Software write wins over counting
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                tmr_reg[t]  <= CCT_RESET_16;
                rld_reg[t]  <= CCT_RESET_16;
                step_reg[t] <= 1'b0;
                ovf_reg[t]  <= 1'b0;
            end else begin
                step_reg[t] <= 1'b0;
                ovf_reg[t]  <= 1'b0;
                if (wr_hit(t == 0 ? CCT_RLD_A_OFS : CCT_RLD_B_OFS)) begin
                    rld_reg[t] <= hwdata[15:0];
                end
                if (wr_tmr[t]) begin
                    tmr_reg[t] <= hwdata[15:0];
                end else if (run[t] && tick[t]) begin
                    step_reg[t] <= 1'b1;
                    if (tmr_reg[t] == CCT_TMR_TOP) begin
                        tmr_reg[t] <= rld_reg[t];
                        ovf_reg[t] <= 1'b1;
                    end else begin
                        tmr_reg[t] <= tmr_reg[t] + 16'h0001;
                    end
                end
            end
        end
    end

    // ****************************************
    // Channel array
    // ****************************************
    logic [NCH-1:0] set_req, clr_req, tog_req, cap_fire;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        cct_mode_t mode;
        logic      tsel, svc, hit, act, allowed;
        logic      pend_reg, per_done_reg, sev_done_reg, wr_ctl;
        assign mode    = cct_mode_t'(cctl_reg[i][CCT_CH_MODE +: 3]);
        assign tsel    = cctl_reg[i][CCT_CH_TSEL];
        assign wr_ctl  = wr_pend_reg && wr_addr_reg[7:6] == CCT_CH_CTRL_PAGE
                         && wr_addr_reg[5:2] == 4'(i);
        assign svc     = !stagger || slot_reg == 3'(i);

        always_comb begin
            case (mode)
                CCT_CAP_RISE: hit = pin_s2[i] && !pin_s3[i];
                CCT_CAP_FALL: hit = !pin_s2[i] && pin_s3[i];
                CCT_CAP_BOTH: hit = pin_s2[i] != pin_s3[i];
                CCT_OFF:      hit = 1'b0;
                default:      hit = step_reg[tsel] && tmr_reg[tsel] == cval_reg[i];
            endcase
        end

        assign act     = (pend_reg || hit) && svc;
        assign allowed = !(cctl_reg[i][CCT_CH_SINGLE] && sev_done_reg)
                         && !((mode == CCT_CMP2 || mode == CCT_CMP3) && per_done_reg);
        assign fire[i]     = act && allowed;
        assign cap_fire[i] = fire[i] && mode inside {CCT_CAP_RISE, CCT_CAP_FALL, CCT_CAP_BOTH};
        assign tog_req[i]  = fire[i] && mode == CCT_CMP1;
        assign set_req[i]  = fire[i] && mode == CCT_CMP3;
        assign clr_req[i]  = ovf_reg[tsel] && mode == CCT_CMP3;

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cctl_reg[i]  <= '0;
                pend_reg     <= 1'b0;
                per_done_reg <= 1'b0;
                sev_done_reg <= 1'b0;
            end else begin
                pend_reg <= (pend_reg || hit) && !svc;
                if (wr_ctl) begin
                    cctl_reg[i]  <= hwdata[CCT_CH_CTRL_W-1:0];
                    per_done_reg <= 1'b0;
                    sev_done_reg <= 1'b0;
                end else begin
                    if (fire[i]) begin
                        sev_done_reg <= 1'b1;
                    end
                    if (ovf_reg[tsel]) begin
                        per_done_reg <= 1'b0;
                    end else if (fire[i]) begin
                        per_done_reg <= 1'b1;
                    end
                end
            end
        end

        // Software write wins over a capture in the same cycle
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cval_reg[i] <= CCT_RESET_16;
            end else if (wr_pend_reg && wr_addr_reg[7:6] == CCT_CH_VAL_PAGE && wr_addr_reg[5:2] == 4'(i)) begin
                cval_reg[i] <= hwdata[15:0];
            end else if (cap_fire[i]) begin
                cval_reg[i] <= tmr_reg[tsel];
            end
        end
    end

    // ****************************************
    // Pins: channel k+8 may share pin k
    // ****************************************
    for (genvar i = 0; i < NCH; i++) begin : g_pin
        logic tog, drv;
        if (i < 8) begin : g_lo
            assign tog = tog_req[i] ^ (dbl_reg[i] && tog_req[i+8]);
            assign drv = (dbl_reg[i] && g_ch[i+8].mode == CCT_CMP1);
        end else begin : g_hi
            assign tog = tog_req[i] && !dbl_reg[i-8];
            assign drv = 1'b0;
        end
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pin_reg[i]  <= 1'b0;
                oe_n_reg[i] <= 1'b1;
            end else begin
                oe_n_reg[i] <= !(drv || g_ch[i].mode == CCT_CMP1 || g_ch[i].mode == CCT_CMP3);
                if (set_req[i]) begin
                    pin_reg[i] <= 1'b1;
                end else if (clr_req[i]) begin
                    pin_reg[i] <= 1'b0;
                end else if (tog) begin
                    pin_reg[i] <= !pin_reg[i];
                end
            end
        end
    end
    assign pin_out  = pin_reg;
    assign pin_oe_n = oe_n_reg;

    // ****************************************
    // Interrupts
    // ****************************************
    // Every capture or compare action flags its channel; set beats clear
    assign st_set = {ovf_reg[1], ovf_reg[0], fire};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= '0;
            irq_reg    <= 1'b0;
        end else begin
            if (wr_hit(CCT_STATUS_OFS)) begin
                status_reg <= (status_reg & ~hwdata[CCT_ST_W-1:0]) | st_set;
            end else begin
                status_reg <= status_reg | st_set;
            end
            irq_reg <= |(status_reg & mask_reg);
        end
    end
    assign irq = irq_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_timer_count: assert property (run[0] && tick[0] && !wr_tmr[0] && tmr_reg[0] != CCT_TMR_TOP
        |=> tmr_reg[0] == $past(tmr_reg[0]) + 16'h0001) else $error("time base did not advance");
    a_ovf_reload: assert property (ovf_reg[0] |-> tmr_reg[0] == $past(rld_reg[0])
        && $past(tmr_reg[0]) == CCT_TMR_TOP) else $error("reload after overflow wrong");
    a_capture_value: assert property (cap_fire[0] && !wr_pend_reg
        |=> cval_reg[0] == $past(tmr_reg[g_ch[0].tsel])) else $error("capture value wrong");
    // Mask sampled a cycle back, since irq lags the status by one register
    a_capture_flag: assert property (cap_fire[0]
        |=> status_reg[0] ##1 (irq || !$past(mask_reg[0]))) else $error("capture flag missing");
    a_mode1_toggle: assert property (tog_req[0] != (dbl_reg[0] && tog_req[8])
        && !set_req[0] && !clr_req[0] |=> pin_out[0] != $past(pin_out[0]))
        else $error("mode 1 pin did not toggle");
    a_mode3_set: assert property (fire[11] && g_ch[11].mode == CCT_CMP3 |=> pin_out[11])
        else $error("mode 3 pin not set");
    a_mode3_clear: assert property (g_ch[11].mode == CCT_CMP3 && ovf_reg[g_ch[11].tsel] && !fire[11]
        |=> !pin_out[11]) else $error("mode 3 pin not cleared");
    a_once_period: assert property (g_ch[10].mode == CCT_CMP2 && g_ch[10].per_done_reg |-> !fire[10])
        else $error("second mode 2 event in one period");
    a_single_event: assert property (g_ch[12].sev_done_reg && cctl_reg[12][CCT_CH_SINGLE] |-> !fire[12])
        else $error("single event repeated");
    a_stagger_slot: assert property (stagger |-> (fire & ~{2{8'h01 << slot_reg}}) == '0)
        else $error("staggered service off slot");

    c_capture: cover property (cap_fire[0]);
    c_toggle: cover property (tog_req[12]);
    c_overflow: cover property (ovf_reg[0]);
    c_double: cover property (dbl_reg[0] && tog_req[8]);
endmodule

// >>> cct_far.sv
`timescale 1ns/1ps
module cct_far (
    input  wire logic        hclk,        // System clock
    input  wire logic [15:0] pin_out,     // Levels driven by the unit
    input  wire logic [15:0] pin_oe_n,    // Low where the unit drives
    output logic      [15:0] pin_in,      // Resolved pin levels
    output logic             gp_ovf_in,   // Overflow pulses of the outer timer
    output logic             ext_cnt_in   // External count pin
);
    logic [15:0] ext_lvl;

    initial begin
        ext_lvl    = 16'h0000;
        gp_ovf_in  = 1'b0;
        ext_cnt_in = 1'b0;
    end

    // Unit-owned pins show the unit level, the rest show ours
    always_comb pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);

    task automatic set_pin(input int ch, input logic lvl);
        @(posedge hclk);
        ext_lvl[ch] <= lvl;
    endtask

    // Same-clock source, so one-cycle pulses are legal
    task automatic pulse_gp(input int n);
        repeat (n) begin
            @(posedge hclk);
            gp_ovf_in <= 1'b1;
            @(posedge hclk);
            gp_ovf_in <= 1'b0;
        end
    endtask

    // Wide pulses so the synchroniser never drops one
    task automatic pulse_ext(input int n);
        repeat (n) begin
            @(posedge hclk);
            ext_cnt_in <= 1'b1;
            repeat (4) @(posedge hclk);
            ext_cnt_in <= 1'b0;
            repeat (4) @(posedge hclk);
        end
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    import cct_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, gp_ovf_in, ext_cnt_in;
    logic [31:0] haddr, hwdata, hrdata, rd, v, rnd_state;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] pin_in, pin_out, pin_oe_n;
    int          n_mismatch, total_checks, c, n, pi;
    int          cfg [5] = '{5, 4, 6, 7, 21};
    logic [4:0]  lvl [3] = '{5'b11001, 5'b11000, 5'b10000};

    cct_capcom u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .gp_ovf_in(gp_ovf_in), .ext_cnt_in(ext_cnt_in), .irq(irq));
    cct_far u_far (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
        .gp_ovf_in(gp_ovf_in), .ext_cnt_in(ext_cnt_in));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xrand();
        rnd_state = rnd_state ^ (rnd_state << 13);
        rnd_state = rnd_state ^ (rnd_state >> 17);
        rnd_state = rnd_state ^ (rnd_state << 5);
        return rnd_state;
    endfunction

    function automatic logic [7:0] ch_addr(input logic [1:0] page, input int ch);
        return {page, 4'(ch), 2'b00};
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Address phase held until ready, then data phase held until ready
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdv(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // ****************************************
    // Clock, watchdog, main sequence
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    initial begin
        #2_000_000;
        n_mismatch++;
        test_done();
    end

    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; rnd_state = 32'h394d_f43c; n_mismatch = 0; total_checks = 0;
        repeat (16) @(posedge hclk);
        chk("oe_n_reset", 32'h0000_ffff, {16'h0000, pin_oe_n});
        hresetn <= 1'b1;
        while (hreadyout !== 1'b1) @(posedge hclk);
        chk("hready_idle", 32'h0000_0001, {31'h0, hreadyout});
        chk("hresp_okay", 32'h0000_0000, {31'h0, hresp});
        rdv(CCT_CTRL_OFS);
        chk("ctrl_reset", 32'h0000_0000, rd);
        rdv(CCT_TMR_A_OFS);
        chk("tmr_a_reset", 32'h0000_0000, rd);
        wr(8'h3C, xrand());
        rdv(8'h3C);
        chk("unmapped", 32'h0000_0000, rd);
        $display("reset test done");

        // Capture on each edge kind, plain on time base A, then staggered on time base B
        for (int s = 0; s < 2; s++) begin
            for (int m = 1; m <= 3; m++) begin
                c = (s == 0 && m == 1) ? 0 : xrand() % 8;
                v = xrand() & 32'h0000_ffff;
                wr(s ? CCT_TMR_B_OFS : CCT_TMR_A_OFS, v);
                wr(CCT_CTRL_OFS, 32'(s));
                wr(CCT_MASK_OFS, 32'h1 << c);
                wr(ch_addr(CCT_CH_CTRL_PAGE, c), 32'(m | (s << 3)));
                wr(CCT_STATUS_OFS, 32'h0003_ffff);
                u_far.set_pin(c, 1'b1);
                repeat (14) @(posedge hclk);
                rdv(CCT_STATUS_OFS);
                chk("cap_rise", 32'(m != 2) << c, rd);
                chk("irq_set", 32'(m != 2), {31'h0, irq});
                wr(CCT_STATUS_OFS, 32'h0003_ffff);
                wr(CCT_MASK_OFS, 32'h0000_0000);
                u_far.set_pin(c, 1'b0);
                repeat (14) @(posedge hclk);
                rdv(CCT_STATUS_OFS);
                chk("cap_fall", 32'(m != 1) << c, rd);
                chk("irq_masked", 32'h0, {31'h0, irq});
                rdv(ch_addr(CCT_CH_VAL_PAGE, c));
                chk("cap_val", v, rd);
                wr(ch_addr(CCT_CH_CTRL_PAGE, c), 32'h0);
            end
        end
        $display("capture test done");

        // Channels 8..12: mode1 on shared pin 0, mode0, mode2, mode3, mode1 single
        v = 32'h0000_0100 + (xrand() & 32'h0000_7fff);
        wr(CCT_DBL_OFS, 32'h0000_0001);
        wr(CCT_RLD_A_OFS, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            wr(ch_addr(CCT_CH_VAL_PAGE, 8 + i), v);
            wr(ch_addr(CCT_CH_CTRL_PAGE, 8 + i), 32'(cfg[i]));
        end
        for (int p = 0; p < 3; p++) begin
            wr(CCT_STATUS_OFS, 32'h0003_ffff);
            wr(CCT_TMR_A_OFS, (p == 2) ? 32'h0000_ffff : v - 1);
            wr(CCT_CTRL_OFS, 32'h0000_002a);
            repeat (48) @(posedge hclk);
            wr(CCT_CTRL_OFS, 32'h0000_0028);
            rdv(CCT_STATUS_OFS);
            for (int i = 0; i < 5; i++) begin
                pi = (i == 0) ? 0 : 8 + i;
                chk("cmp_event", (p == 2) ? 0 : ((p == 0) ? 1 : 32'(i < 2)), 32'(rd[8 + i]));
                chk("cmp_oe_n", 32'(cfg[i] == 4 || cfg[i] == 6), 32'(pin_oe_n[pi]));
                chk("cmp_pin", 32'(lvl[p][i]), 32'(pin_out[pi] & !pin_oe_n[pi]));
            end
        end
        chk("ovf_flag", 32'h1, 32'(rd[CCT_ST_OVF_A]));
        rdv(CCT_TMR_A_OFS);
        chk("tmr_reload", 32'h0, rd & 32'hffff_fffe);
        rdv(CCT_PIN_OFS);
        chk("pin_levels", 32'h0000_1000, rd);
        $display("compare test done");

        // Time base B clocked by outer overflow pulses, then by the count pin
        for (int k = 0; k < 2; k++) begin
            n = 1 + xrand() % 6;
            wr(CCT_TMR_B_OFS, 32'h0000_0000);
            wr(CCT_CTRL_OFS, k ? 32'h0000_01c4 : 32'h0000_0184);
            if (k) u_far.pulse_ext(n);
            else u_far.pulse_gp(n);
            repeat (6) @(posedge hclk);
            wr(CCT_CTRL_OFS, 32'h0000_0000);
            rdv(CCT_TMR_B_OFS);
            chk("tmr_b_count", 32'(n), rd);
        end
        $display("count source test done");
        test_done();
    end
endmodule
